// *** hw/etc_cfg.svh ***
// constants of the eight-bit compare timer: register indices, field
// positions and reset values.
// assumes it is included by bare name from the package and the top.
`ifndef ETC_CFG_SVH
`define ETC_CFG_SVH

// ************************************************************
// register indices (byte address is four times the index)
// ************************************************************
`define ETC_IDX_CH1_CTL 8'hce
`define ETC_IDX_CH1_LVL 8'hcf
`define ETC_IDX_FLAGS   8'hd8
`define ETC_IDX_MASK    8'hd9
`define ETC_IDX_COUNT   8'hea
`define ETC_IDX_TCTL    8'heb
`define ETC_IDX_CH0_CTL 8'hec
`define ETC_IDX_CH0_LVL 8'hed

// ************************************************************
// field positions
// ************************************************************
`define ETC_FLAG_LSB    3
`define ETC_FLAG_MSB    5
`define ETC_TCTL_CLR    2

// ************************************************************
// reset values
// ************************************************************
`define ETC_TCTL_RST    8'h08
`define ETC_CCTL_RST    8'h40
`define ETC_LVL_RST     8'h00
`define ETC_CNT_RST     8'h00
`define ETC_FLAGS_RST   3'h0
`define ETC_MASK_RST    3'h7
`define ETC_PRE_RST     7'h00

`endif

// *** hw/etc_pkg.sv ***
// types of the eight-bit compare timer: modes, output actions,
// count direction and the packed control layouts.
// assumes etc_cfg.svh sits on the include path.
`include "etc_cfg.svh"

package etc_pkg;

  // counting modes, encoded as in the mode field
  typedef enum logic [1:0] {
    ETC_MODE_FREE = 2'h0,
    ETC_MODE_DOWN = 2'h1,
    ETC_MODE_MOD  = 2'h2,
    ETC_MODE_UPDN = 2'h3
  } etc_mode_e;

  // channel output actions
  typedef enum logic [2:0] {
    ETC_ACT_SET     = 3'h0,
    ETC_ACT_CLR     = 3'h1,
    ETC_ACT_TGL     = 3'h2,
    ETC_ACT_SET_UP  = 3'h3,
    ETC_ACT_CLR_UP  = 3'h4,
    ETC_ACT_SET_ALT = 3'h5,
    ETC_ACT_CLR_ALT = 3'h6,
    ETC_ACT_NONE    = 3'h7
  } etc_act_e;

  // count direction, one-hot
  typedef enum logic [1:0] {
    ETC_DIR_UP = 2'b01,
    ETC_DIR_DN = 2'b10
  } etc_dir_e;

  // timer control byte
  typedef struct packed {
    logic [2:0] div;
    logic       run;
    logic       overflow_irq_gate;
    logic       counter_zero_strobe;
    etc_mode_e  mode;
  } etc_tctl_s;

  // channel compare control byte
  typedef struct packed {
    logic       unused;
    logic       channel_irq_gate;
    etc_act_e   output_action_select;
    logic       cmp_en;
    logic [1:0] rsvd;
  } etc_cctl_s;

  // per-channel events of one counter step
  typedef struct packed {
    logic match;
    logic up;
    logic zero;
    logic alt;
  } etc_evt_s;

endpackage

// *** hw/etc_timer.sv ***
// eight-bit timer with prescaler, four counting modes and two compare
// channels, registers reached over apb.
// assumes sys_tick is a one-cycle pulse made on ref_clk, and an apb
// master on ref_clk.
`timescale 1ns/1ps
`default_nettype none
`include "etc_cfg.svh"

module etc_timer (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        sys_tick,
  output var  logic [1:0]  cmp_out,
  output var  logic        irq
);
  import etc_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  etc_tctl_s  tctl_reg;
  etc_cctl_s  cctl_reg [2];
  logic [7:0] lvl_reg [2];
  logic [7:0] count_byte_reg;
  logic [7:0] cnt_next;
  etc_dir_e   dir_reg;
  etc_dir_e   dir_next;
  logic [6:0] pre_reg;
  logic [6:0] div_mask;
  logic [2:0] flags_reg;
  logic [2:0] flags_next;
  logic [2:0] mask_reg;
  logic [2:0] gates;
  logic       step;
  logic       moved;
  logic       step_up;
  logic       ovf_evt;
  etc_evt_s   evt [2];
  logic [1:0] out_next;

  // bus decode
  logic       addr_ok;
  logic [7:0] idx;
  logic       wr_en;
  logic       rd_hit;
  logic [7:0] rd_data;
  logic       wr_tctl;
  logic       clr_wr;
  logic       load_wr;
  logic       wr_flags;

  // ************************************************************
  // apb slave
  // ************************************************************

  // byte address is index times four, upper bits must be zero
  assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
  assign idx = paddr[9:2];
  // writes land only at the completing edge of the access phase
  assign wr_en = psel && penable && pready && pwrite && addr_ok;
  assign wr_tctl = wr_en && (idx == `ETC_IDX_TCTL);
  assign wr_flags = wr_en && (idx == `ETC_IDX_FLAGS);
  assign clr_wr = wr_tctl && pwdata[`ETC_TCTL_CLR];
  // down mode has nothing to count from after a clear, so starting
  // the timer into down mode loads the channel 0 level
  assign load_wr = wr_tctl && pwdata[4] && !tctl_reg.run
                   && (pwdata[1:0] == ETC_MODE_DOWN);

  // read mux
  always_comb begin
    rd_hit = addr_ok;
    rd_data = 8'h00;
    if (idx == `ETC_IDX_COUNT) begin
      rd_data = count_byte_reg;
    end else if (idx == `ETC_IDX_TCTL) begin
      rd_data = tctl_reg; // clear bit is stored as zero
    end else if (idx == `ETC_IDX_CH0_CTL) begin
      rd_data = cctl_reg[0];
    end else if (idx == `ETC_IDX_CH0_LVL) begin
      rd_data = lvl_reg[0];
    end else if (idx == `ETC_IDX_CH1_CTL) begin
      rd_data = cctl_reg[1];
    end else if (idx == `ETC_IDX_CH1_LVL) begin
      rd_data = lvl_reg[1];
    end else if (idx == `ETC_IDX_FLAGS) begin
      rd_data = {2'h0, flags_reg, 3'h0};
    end else if (idx == `ETC_IDX_MASK) begin
      rd_data = {2'h0, mask_reg, 3'h0};
    end else begin
      rd_hit = 1'b0;
    end
  end

  // one wait state: answer registered in the first access cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= !rd_hit;
      prdata <= (pwrite || !rd_hit) ? 32'h00000000 : {24'h000000, rd_data};
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ************************************************************
  // control registers
  // ************************************************************

  // timer control; clear bit never stored
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tctl_reg <= `ETC_TCTL_RST;
    end else if (wr_tctl) begin
      tctl_reg <= pwdata[7:0] & 8'hfb;
    end
  end

  // channel controls and levels, control bit 7 reads zero
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cctl_reg[0] <= `ETC_CCTL_RST; // gate resets one, enable zero
      cctl_reg[1] <= `ETC_CCTL_RST;
      lvl_reg[0] <= `ETC_LVL_RST;
      lvl_reg[1] <= `ETC_LVL_RST;
    end else if (wr_en) begin
      if (idx == `ETC_IDX_CH0_CTL) begin
        cctl_reg[0] <= pwdata[7:0] & 8'h7f;
      end else if (idx == `ETC_IDX_CH1_CTL) begin
        cctl_reg[1] <= pwdata[7:0] & 8'h7f;
      end else if (idx == `ETC_IDX_CH0_LVL) begin
        lvl_reg[0] <= pwdata[7:0];
      end else if (idx == `ETC_IDX_CH1_LVL) begin
        lvl_reg[1] <= pwdata[7:0];
      end
    end
  end

  // ************************************************************
  // prescaler and counter
  // ************************************************************

  // mask of low prescaler bits that must be all ones for an edge
  assign div_mask = 7'((8'h01 << tctl_reg.div) - 8'h01);
  assign step = sys_tick && tctl_reg.run
                && ((pre_reg & div_mask) == div_mask);

  // free-running prescaler; not cleared with the counter
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pre_reg <= `ETC_PRE_RST;
    end else if (sys_tick) begin
      pre_reg <= pre_reg + 7'h01;
    end
  end

  // next count per mode; a clear beats a step in the same cycle
  always_comb begin
    cnt_next = count_byte_reg;
    dir_next = dir_reg;
    moved = 1'b0;
    step_up = 1'b1;
    ovf_evt = 1'b0;
    if (clr_wr) begin
      cnt_next = 8'h00;
      dir_next = ETC_DIR_UP;
    end else if (load_wr) begin
      cnt_next = lvl_reg[0];
      dir_next = ETC_DIR_DN;
    end else if (step) begin
      moved = 1'b1;
      case (tctl_reg.mode)
        ETC_MODE_FREE: begin
          cnt_next = count_byte_reg + 8'h01;
          ovf_evt = (count_byte_reg == 8'hff);
        end
        ETC_MODE_DOWN: begin
          // holds at zero until restarted
          if (count_byte_reg != 8'h00) begin
            cnt_next = count_byte_reg - 8'h01;
            step_up = 1'b0;
            ovf_evt = (count_byte_reg == 8'h01);
          end else begin
            moved = 1'b0;
          end
        end
        ETC_MODE_MOD: begin
          // above the level also wraps, so a lowered level cannot run away
          if (count_byte_reg >= lvl_reg[0]) begin
            cnt_next = 8'h00;
            ovf_evt = 1'b1;
          end else begin
            cnt_next = count_byte_reg + 8'h01;
          end
        end
        default: begin
          if (dir_reg == ETC_DIR_UP) begin
            if (count_byte_reg >= lvl_reg[0]) begin
              dir_next = ETC_DIR_DN;
              if (count_byte_reg != 8'h00) begin
                cnt_next = count_byte_reg - 8'h01;
                step_up = 1'b0;
              end
            end else begin
              cnt_next = count_byte_reg + 8'h01;
            end
          end else begin
            step_up = 1'b0;
            if (count_byte_reg <= 8'h01) begin
              dir_next = ETC_DIR_UP;
            end
            if (count_byte_reg != 8'h00) begin
              cnt_next = count_byte_reg - 8'h01;
              ovf_evt = (count_byte_reg == 8'h01);
            end
          end
        end
      endcase
    end
  end

  // counter and direction
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count_byte_reg <= `ETC_CNT_RST;
      dir_reg <= ETC_DIR_UP;
    end else begin
      count_byte_reg <= cnt_next;
      dir_reg <= dir_next;
    end
  end

  // ************************************************************
  // compare channels
  // ************************************************************

  // output action for one channel on one step
  function automatic logic act_next(input logic cur, input etc_act_e a,
                                    input etc_evt_s e, input logic updn);
    logic r;
    r = cur;
    case (a)
      ETC_ACT_SET: if (e.match) r = 1'b1;
      ETC_ACT_CLR: if (e.match) r = 1'b0;
      ETC_ACT_TGL: if (e.match) r = !cur;
      ETC_ACT_SET_UP: begin
        if (e.match) begin
          r = updn ? e.up : 1'b1;
        end else if (!updn && e.zero) begin
          r = 1'b0;
        end
      end
      ETC_ACT_CLR_UP: begin
        if (e.match) begin
          r = updn ? !e.up : 1'b0;
        end else if (!updn && e.zero) begin
          r = 1'b1;
        end
      end
      ETC_ACT_SET_ALT: begin
        if (e.match) begin
          r = 1'b1;
        end else if (e.alt) begin
          r = 1'b0;
        end
      end
      ETC_ACT_CLR_ALT: begin
        if (e.match) begin
          r = 1'b0;
        end else if (e.alt) begin
          r = 1'b1;
        end
      end
      default: r = cur; // unused code leaves the pin alone
    endcase
    return r;
  endfunction

  // events on the value just reached; match beats the second event
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      evt[i].match = moved && cctl_reg[i].cmp_en
                     && (cnt_next == lvl_reg[i]);
      evt[i].up = step_up;
      evt[i].zero = moved && cctl_reg[i].cmp_en && (cnt_next == 8'h00);
    end
    // channel 0 second event is zero, channel 1 uses the level 0 hit;
    // both settle before any action reads them, else a stale alt leaks in
    evt[0].alt = evt[0].zero;
    evt[1].alt = moved && cctl_reg[1].cmp_en
                 && (cnt_next == lvl_reg[0]);
    for (int j = 0; j < 2; j++) begin
      out_next[j] = act_next(cmp_out[j], cctl_reg[j].output_action_select,
                             evt[j], tctl_reg.mode == ETC_MODE_UPDN);
    end
  end

  // channel output pins
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cmp_out <= 2'h0;
    end else begin
      cmp_out <= out_next;
    end
  end

  // ************************************************************
  // interrupt flags
  // ************************************************************

  // writing zero clears a flag; an event in the same cycle still sets it
  always_comb begin
    flags_next = flags_reg;
    if (wr_flags) begin
      flags_next = flags_reg & pwdata[`ETC_FLAG_MSB:`ETC_FLAG_LSB];
    end
    flags_next = flags_next | {evt[1].match, evt[0].match, ovf_evt};
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flags_reg <= `ETC_FLAGS_RST;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // extra enable mask in the flag layout
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mask_reg <= `ETC_MASK_RST;
    end else if (wr_en && (idx == `ETC_IDX_MASK)) begin
      mask_reg <= pwdata[`ETC_FLAG_MSB:`ETC_FLAG_LSB];
    end
  end

  // flags stay pending when gated off, only the request is held back
  assign gates = {cctl_reg[1].channel_irq_gate, cctl_reg[0].channel_irq_gate,
                  tctl_reg.overflow_irq_gate};

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flags_reg & mask_reg & gates);
    end
  end

endmodule
`default_nettype wire

// *** verification/etc_timer_checker.sv ***
// port assertions for the eight-bit compare timer.
// assumes it is bound onto etc_timer: one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module etc_timer_checker (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sys_tick,
  input wire logic [1:0]  cmp_out,
  input wire logic        irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  // ************************************************************
  // bus answer
  // ************************************************************
  // first access cycle, then a one-cycle answer
  sequence s_acc;
    psel && penable && !pready;
  endsequence
  sequence s_ans;
    pready ##1 !pready;
  endsequence

  a_apb_one_wait: assert property (s_acc |=> s_ans)
    else $error("answer not one cycle after access");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside an access");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read lanes not zero");
  a_read_data_hold: assert property ($changed(prdata) |-> pready)
    else $error("read data moved without an answer");
  a_err_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");

  // ************************************************************
  // timer side
  // ************************************************************
  // outputs only move on a counter step, never on a bus write
  a_out_on_step: assert property ($changed(cmp_out) |-> $past(sys_tick))
    else $error("channel output moved without a tick");
  a_irq_rise_cause: assert property (
    $rose(irq) |-> $past(sys_tick, 2) || $past(pready, 2))
    else $error("irq rose without event or write");
  a_irq_fall_write: assert property ($fell(irq) |-> $past(pready, 2))
    else $error("irq fell without a write");
endmodule
`default_nettype wire

// *** verification/etc_timer_tb.sv ***
// self-checking bench for the eight-bit compare timer.
// assumes etc_cfg.svh on the include path and the checker compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "etc_cfg.svh"
module etc_timer_tb;
  localparam logic [7:0] CTL = `ETC_IDX_TCTL;
  localparam logic [7:0] CNT = `ETC_IDX_COUNT;
  localparam logic [7:0] C0C = `ETC_IDX_CH0_CTL;
  localparam logic [7:0] C0L = `ETC_IDX_CH0_LVL;
  localparam logic [7:0] C1C = `ETC_IDX_CH1_CTL;
  localparam logic [7:0] C1L = `ETC_IDX_CH1_LVL;
  localparam logic [7:0] FLG = `ETC_IDX_FLAGS;
  localparam logic [7:0] MSK = `ETC_IDX_MASK;
  logic            ref_clk, rst, psel, penable, pwrite, sys_tick;
  logic     [11:0] paddr;
  logic     [31:0] pwdata;
  wire logic [31:0] prdata;
  wire logic       pready, pslverr, irq;
  wire logic [1:0] cmp_out;
  logic     [7:0]  rdat;
  logic            rerr;
  logic     [15:0] tab [5];
  int              fail_count, checks;

  etc_timer etc_timer_i (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sys_tick(sys_tick), .cmp_out(cmp_out), .irq(irq));

  // 40 mhz clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one apb transfer; bounded wait, no assumed latency
  task automatic xfer(input logic w, input logic [7:0] i, input logic [7:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {2'b00, i, 2'b00};
    pwdata  <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk(pready, 8'h01);
    rdat = prdata[7:0];
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    xfer(1'b1, i, d);
  endtask

  task automatic rd(input logic [7:0] i, input logic [7:0] exp);
    xfer(1'b0, i, 8'h00);
    chk(rdat, exp);
  endtask

  // one-cycle tick pulses with a gap, so every tick is a step candidate
  task automatic tick(input int n);
    repeat (n) begin
      sys_tick <= 1'b1;
      @(posedge ref_clk);
      sys_tick <= 1'b0;
      @(posedge ref_clk);
    end
  endtask

  // irq lags the register write by one edge
  task automatic idle;
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic conclude;
    $display("checks=%0d mismatches=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // hang guard, well beyond the ~3000 cycles the tests need
  initial begin
    #200000;
    fail_count++;
    conclude;
  end

  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; sys_tick = 1'b0;
    fail_count = 0; checks = 0;
    tab = '{16'h4401, 16'h4c00, 16'h5401, 16'h5400, 16'h4000};
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd(CNT, 8'h00);
    rd(CTL, 8'h08);
    rd(C0C, 8'h40);
    rd(C1C, 8'h40);
    rd(C1L, 8'h00);
    rd(FLG, 8'h00);
    rd(MSK, 8'h38);
    xfer(1'b0, 8'h00, 8'h00);
    chk(rerr, 8'h01);
    wr(CNT, 8'h55); rd(CNT, 8'h00);
    wr(C1L, 8'ha5); rd(C1L, 8'ha5);
    wr(C1C, 8'h90); rd(C1C, 8'h10);
    $display("test registers done");
    wr(CTL, 8'h10); tick(5); rd(CNT, 8'h05);
    wr(CTL, 8'h14); rd(CTL, 8'h10);
    rd(CNT, 8'h00);
    wr(CTL, 8'h10); tick(2); wr(CTL, 8'h00); tick(3); rd(CNT, 8'h02);
    wr(FLG, 8'h00); wr(CTL, 8'h10); tick(253); rd(FLG, 8'h00);
    tick(1); rd(CNT, 8'h00);
    rd(FLG, 8'h08);
    chk(irq, 8'h00);
    wr(CTL, 8'h08); idle; chk(irq, 8'h01);
    wr(MSK, 8'h30); idle; chk(irq, 8'h00);
    wr(MSK, 8'h38); idle; chk(irq, 8'h01);
    wr(FLG, 8'h00); idle; chk(irq, 8'h00);
    $display("test free run and overflow done");
    // whole multiples of the divisor keep the result phase-free
    for (int d = 0; d < 8; d++) begin
      wr(CTL, {d[2:0], 5'h14}); tick(2 << d); rd(CNT, 8'h02);
    end
    wr(C0L, 8'h03); wr(CTL, 8'h16); tick(4); rd(CNT, 8'h00);
    tick(2); rd(CNT, 8'h02);
    wr(C0L, 8'h04); wr(CTL, 8'h00); wr(CTL, 8'h11);
    tick(3); rd(CNT, 8'h01);
    tick(2); rd(CNT, 8'h00);
    wr(C1L, 8'h01); wr(C1C, 8'h5c); wr(C0L, 8'h02); wr(CTL, 8'h17);
    tick(1); chk(cmp_out[1], 8'h01);
    tick(2); rd(CNT, 8'h01);
    chk(cmp_out[1], 8'h00);
    tick(1); rd(CNT, 8'h00);
    $display("test modes done");
    wr(C1L, 8'h02);
    for (int i = 0; i < 5; i++) begin
      wr(C1C, tab[i][15:8]); wr(CTL, 8'h14); tick(2);
      chk(cmp_out[1], tab[i][7:0]);
    end
    wr(C0L, 8'h03); wr(C0C, 8'h6c); wr(C1L, 8'h01); wr(C1C, 8'h74);
    wr(CTL, 8'h14); tick(3);
    chk(cmp_out[0], 8'h01);
    chk(cmp_out[1], 8'h01);
    tick(253);
    chk(cmp_out[0], 8'h00);
    tick(1);
    chk(cmp_out[1], 8'h00);
    rd(FLG, 8'h38);
    wr(FLG, 8'h20); idle; chk(irq, 8'h01);
    wr(C1C, 8'h34); idle; chk(irq, 8'h00);
    // ch0 clear-up code outside up/down, ch1 set-on-match with level 0 clear
    wr(C0C, 8'h64); wr(C1C, 8'h2c); wr(CTL, 8'h14);
    tick(1); chk(cmp_out[1], 8'h01);
    tick(2); chk(cmp_out[1], 8'h00);
    tick(253); chk(cmp_out[0], 8'h01);
    tick(3); chk(cmp_out[0], 8'h00);
    chk(irq, 8'h01);
    $display("test compare outputs done");
    // mid-run reset, held past two edges so no checker sees a half release
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    chk(irq, 8'h00);
    rd(FLG, 8'h00);
    rd(C0C, 8'h40);
    $display("test mid-run reset done");
    conclude;
  end
endmodule

bind etc_timer etc_timer_checker etc_timer_checker_i (.ref_clk(ref_clk),
  .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sys_tick(sys_tick), .cmp_out(cmp_out), .irq(irq));
`default_nettype wire
